//--- design/edge_prog_map.vh
// Constants for the edge-count program receiver
`ifndef EDGE_PROG_MAP_VH
`define EDGE_PROG_MAP_VH
`define CLK_PERIOD_PS        5000
`define LATCH_TIMEOUT_US     500
`define SHUTDOWN_TIMEOUT_US  500
`define LATCH_TIMEOUT_CYC    ((`LATCH_TIMEOUT_US * 1000000) / `CLK_PERIOD_PS)
`define SHUTDOWN_TIMEOUT_CYC ((`SHUTDOWN_TIMEOUT_US * 1000000) / `CLK_PERIOD_PS)
`define ADDR_VOLTAGE         1'h0
`define ADDR_CURRENT         1'h1
`define EDGES_VOLTAGE        5'h11
`define EDGES_CURRENT        5'h12
`define DATA_MAX_EDGES       5'h10
`define EDGE_COUNT_MAX       5'h1F
`define SETTING_RESET        4'h0
`define SETTING_DEFAULT      4'h0
`endif

//--- design/edge_prog_timer.v
// Idle timer: counts cycles the line holds one level, pulses once at the limit
`timescale 1ns/1ps
`default_nettype none
module edge_prog_timer #(
  parameter WIDTH = 17,
  parameter LIMIT = 100000
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_b,
  // Control
  input  wire             restart,
  output reg              expired_r
);
  reg  [WIDTH-1:0] count_r;
  wire             at_limit;

  assign at_limit = (count_r == LIMIT[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_r   <= {WIDTH{1'b0}};
      expired_r <= 1'b0;
    end else if (restart) begin
      count_r   <= {WIDTH{1'b0}};
      expired_r <= 1'b0;
    end else if (at_limit) begin
      count_r   <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      expired_r <= 1'b1;
    end else begin
      expired_r <= 1'b0;
      if (count_r != LIMIT[WIDTH-1:0])
        count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule // edge_prog_timer
`default_nettype wire

//--- design/edge_prog_receiver.v
// Edge-count program receiver on a single enable/program line
// Operation
// - Rising edges on the program line are counted up to 31 (the count then holds) and the count alone carries address and data.
// - A burst of exactly eighteen edges selects the current register at address 1.
// - A burst of exactly seventeen edges selects the voltage register at address 0.
// - A data burst of 1 to 16 edges picks one of sixteen settings, stored as count minus one.
// - When the latch timeout expires high after a data burst, the addressed register is written and the converter updated.
// - Out of shutdown the pointer is address 0, so a data-only burst programs voltage.
// - Going high with no further edges counts that rise as one data edge, giving the default state, address 0 with data 1.
// - Reprogramming is accepted while the line stays high and unaddressed registers keep their values.
// - Eighteen address edges then one data edge turns the current output off, leaving voltage alone.
// - After the line stays low for the off timeout the device shuts down and clears every register.
`timescale 1ns/1ps
`default_nettype none
`include "edge_prog_map.vh"
module edge_prog_receiver #(
  parameter LATCH_CYCLES    = `LATCH_TIMEOUT_CYC,
  parameter SHUTDOWN_CYCLES = `SHUTDOWN_TIMEOUT_CYC,
  parameter TIMER_WIDTH     = 17
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // Program line
  input  wire       prog_line,
  // Converter codes and status
  output reg  [3:0] voltage_code_r,
  output reg  [3:0] current_code_r,
  output reg        dac_update_r,
  output reg        enabled_r,
  output reg        addr_ptr_r
);
  // Setting codes: 0 = data 1 ... 15 = data 16
  reg        sync1_r;
  reg        sync2_r;
  reg        line_r;
  reg  [4:0] edge_cnt_r;
  reg        pending_r;
  // Next values of the registers
  reg  [4:0] edge_cnt_nxt;
  reg        pending_nxt;
  reg  [3:0] voltage_code_nxt;
  reg  [3:0] current_code_nxt;
  reg        dac_update_nxt;
  reg        enabled_nxt;
  reg        addr_ptr_nxt;
  reg  [2:0] burst_kind;
  wire       latch_restart;
  wire       off_restart;

  // Burst kinds seen when the latch timeout expires
  localparam [2:0] KIND_NONE    = 3'h0;
  localparam [2:0] KIND_DATA    = 3'h1;
  localparam [2:0] KIND_VOLTAGE = 3'h2;
  localparam [2:0] KIND_CURRENT = 3'h3;
  localparam [2:0] KIND_JUNK    = 3'h4;
  // Edge counter values
  localparam [4:0] CNT_ZERO     = 5'h00;
  localparam [4:0] CNT_ONE      = 5'h01;
  // Power states held in enabled_r
  localparam       PWR_OFF      = 1'b0;
  localparam       PWR_ON       = 1'b1;
  wire       rise;
  wire       fall;
  wire       latch_exp;
  wire       off_exp;
  wire [3:0] data_code;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      line_r  <= 1'b0;
    end else begin
      sync1_r <= prog_line;
      sync2_r <= sync1_r;
      line_r  <= sync2_r;
    end
  end

  assign rise      = sync2_r & ~line_r;
  assign fall      = ~sync2_r & line_r;
  assign data_code = edge_cnt_r[3:0] - 4'h1;
  assign latch_restart = rise | fall | ~sync2_r;
  assign off_restart   = rise | fall | sync2_r;

  // Classify the counted burst; counts above the address band (over eighteen) are dropped
  always @* begin
    burst_kind = KIND_NONE;
    if (pending_r) begin
      if (edge_cnt_r == `EDGES_VOLTAGE)
        burst_kind = KIND_VOLTAGE;
      else if (edge_cnt_r == `EDGES_CURRENT)
        burst_kind = KIND_CURRENT;
      else if (edge_cnt_r <= `DATA_MAX_EDGES)
        burst_kind = KIND_DATA;
      else
        burst_kind = KIND_JUNK;
    end
  end

  // Latch timer restarts on any change and while low
  edge_prog_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (LATCH_CYCLES)
  ) u_latch_timer (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .restart   (latch_restart),
    .expired_r (latch_exp)
  );

  // Shutdown timer restarts on any change and while high
  edge_prog_timer #(
    .WIDTH (TIMER_WIDTH),
    .LIMIT (SHUTDOWN_CYCLES)
  ) u_off_timer (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .restart   (off_restart),
    .expired_r (off_exp)
  );

  // Power state: off until a latch timeout passes with the line high
  always @* begin
    enabled_nxt = enabled_r;
    case (enabled_r)
      PWR_OFF: begin
        if (latch_exp)
          enabled_nxt = PWR_ON;
      end
      PWR_ON: begin
        if (off_exp)
          enabled_nxt = PWR_OFF;
      end
      default: begin
        enabled_nxt = PWR_OFF;
      end
    endcase
  end

  // Counter, pointer and setting codes
  always @* begin
    edge_cnt_nxt     = edge_cnt_r;
    pending_nxt      = pending_r;
    voltage_code_nxt = voltage_code_r;
    current_code_nxt = current_code_r;
    addr_ptr_nxt     = addr_ptr_r;
    dac_update_nxt   = 1'b0;
    if (off_exp) begin
      // An edge that lands with the shutdown still counts as the first edge
      edge_cnt_nxt     = rise ? CNT_ONE : CNT_ZERO;
      pending_nxt      = rise;
      voltage_code_nxt = `SETTING_RESET;
      current_code_nxt = `SETTING_RESET;
      addr_ptr_nxt     = `ADDR_VOLTAGE;
      dac_update_nxt   = enabled_r;
    end else if (rise) begin
      if (edge_cnt_r != `EDGE_COUNT_MAX)
        edge_cnt_nxt = edge_cnt_r + CNT_ONE;
      pending_nxt = 1'b1;
    end else if (latch_exp) begin
      edge_cnt_nxt = CNT_ZERO;
      pending_nxt  = 1'b0;
      if (enabled_r == PWR_OFF)
        dac_update_nxt = 1'b1;
      // Address bursts move the pointer, data bursts write the addressed code
      case (burst_kind)
        KIND_VOLTAGE: begin
          addr_ptr_nxt = `ADDR_VOLTAGE;
        end
        KIND_CURRENT: begin
          addr_ptr_nxt = `ADDR_CURRENT;
        end
        KIND_DATA: begin
          // Stored code is the edge count minus one
          if (addr_ptr_r == `ADDR_CURRENT)
            current_code_nxt = data_code;
          else
            voltage_code_nxt = data_code;
          dac_update_nxt = 1'b1;
        end
        KIND_NONE, KIND_JUNK: begin
          // Empty and out-of-band bursts leave the pointer and both setting codes alone
          addr_ptr_nxt = addr_ptr_r;
        end
        default: begin
          addr_ptr_nxt = addr_ptr_r;
        end
      endcase
    end
  end

  // Burst counter
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      edge_cnt_r <= CNT_ZERO;
      pending_r  <= 1'b0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
      pending_r  <= pending_nxt;
    end
  end

  // Outputs, each straight from a flip-flop
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      voltage_code_r <= `SETTING_RESET;
      current_code_r <= `SETTING_RESET;
      dac_update_r   <= 1'b0;
      enabled_r      <= PWR_OFF;
      addr_ptr_r     <= `ADDR_VOLTAGE;
    end else begin
      voltage_code_r <= voltage_code_nxt;
      current_code_r <= current_code_nxt;
      dac_update_r   <= dac_update_nxt;
      enabled_r      <= enabled_nxt;
      addr_ptr_r     <= addr_ptr_nxt;
    end
  end
endmodule // edge_prog_receiver
`default_nettype wire

//--- dv/edge_prog_host.sv
// Host model that toggles the program line
`timescale 1ns/1ps
`default_nettype none
module edge_prog_host #(
  parameter int LOW_CYC  = 60,
  parameter int HIGH_CYC = 20
) (
  // Clock
  input  wire logic clk_sys,
  // Line
  output logic      prog_line
);
  initial prog_line = 1'b0;
  task automatic level(input logic b, input int c);
    @(negedge clk_sys) prog_line = b;
    repeat (c - 1) @(negedge clk_sys);
  endtask
  // Fastest legal phases: 300 ns low, 100 ns high at 5 ns a cycle
  task automatic burst(input int n, input int hold);
    repeat (n) begin
      level(1'b0, LOW_CYC);
      level(1'b1, HIGH_CYC);
    end
    level(1'b1, hold);
  endtask
endmodule // edge_prog_host
`default_nettype wire

//--- dv/edge_prog_asserts.sv
// Checker for the edge-count receiver
`timescale 1ns/1ps
`default_nettype none
module edge_prog_checker (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       prog_line,
  input wire logic [3:0] voltage_code_r,
  input wire logic [3:0] current_code_r,
  input wire logic       dac_update_r,
  input wire logic       enabled_r,
  input wire logic       addr_ptr_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_dac_one_cycle: assert property (dac_update_r |=> !dac_update_r) else $error("long pulse");
  a_codes_need_pulse: assert property (!dac_update_r |-> $stable({voltage_code_r, current_code_r}))
    else $error("code moved");
  a_write_line_high: assert property (dac_update_r && enabled_r |-> $past(prog_line, 10))
    else $error("write low");
  a_shutdown_clears: assert property ($fell(enabled_r) |-> dac_update_r && !addr_ptr_r &&
    {voltage_code_r, current_code_r} == 8'h00) else $error("not cleared");
  a_shutdown_line_low: assert property ($fell(enabled_r) |-> !$past(prog_line, 10) && !$past(prog_line, 50))
    else $error("early off");
  a_ptr_set_high: assert property ($rose(addr_ptr_r) |-> $past(prog_line, 10) && $past(prog_line, 50))
    else $error("early ptr");
  a_ptr_no_write: assert property ($changed(addr_ptr_r) && $past(enabled_r) && enabled_r |-> !dac_update_r)
    else $error("ptr wrote");
  a_enable_default: assert property ($rose(enabled_r) |-> dac_update_r && $past(prog_line, 10))
    else $error("bad enable");
endmodule // edge_prog_checker
bind edge_prog_receiver edge_prog_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .prog_line(prog_line),
  .voltage_code_r(voltage_code_r), .current_code_r(current_code_r), .dac_update_r(dac_update_r),
  .enabled_r(enabled_r), .addr_ptr_r(addr_ptr_r));
`default_nettype wire

//--- dv/edge_prog_receiver_test.sv
// Self-checking bench for the edge-count receiver
`timescale 1ns/1ps
`default_nettype none
module edge_prog_receiver_test;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  wire        prog_line;
  wire  [3:0] voltage_code_r;
  wire  [3:0] current_code_r;
  wire        dac_update_r;
  wire        enabled_r;
  wire        addr_ptr_r;
  int         mismatches = 0;
  int         cmp_count = 0;
  int         pulses = 0;
  int         pc [8] = '{1, 1, 2, 2, 3, 3, 4, 4};
  int         n [8] = '{0, 18, 16, 17, 4, 18, 1, 20};
  logic [9:0] e [8] = '{10'h001, 10'h003, 10'h03F, 10'h03D, 10'h0FD, 10'h0FF, 10'h0C3, 10'h0C3};
  initial forever #2.5 clk_sys = ~clk_sys;
  // Running count of converter update pulses, sampled where they are settled
  always @(negedge clk_sys)
    if (dac_update_r === 1'b1) pulses <= pulses + 1;
  edge_prog_host host (.clk_sys(clk_sys), .prog_line(prog_line));
  edge_prog_receiver #(.LATCH_CYCLES(200), .SHUTDOWN_CYCLES(200)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
    .prog_line(prog_line), .voltage_code_r(voltage_code_r), .current_code_r(current_code_r),
    .dac_update_r(dac_update_r), .enabled_r(enabled_r), .addr_ptr_r(addr_ptr_r));
  // Compares codes, pointer and enable packed as v, c, ptr, en, then the update pulse count
  task automatic chk(input logic [9:0] x, input int np);
    cmp_count += 2;
    if ({voltage_code_r, current_code_r, addr_ptr_r, enabled_r} !== x) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, {voltage_code_r, current_code_r, addr_ptr_r, enabled_r}, x);
    end
    if (pulses != np) begin
      mismatches++;
      $display("Error %0t pulses %h exp %h", $time, pulses, np);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    chk(10'h000, 0);
    for (int i = 0; i < 8; i++) begin
      host.burst(n[i], 240);
      chk(e[i], pc[i]);
      $display("test %0d end", i);
    end
    host.level(1'b0, 240);
    chk(10'h000, 5);
    host.burst(4, 240);
    chk(10'h0C1, 6);
    $display("test shutdown end");
    complete_run();
  end
endmodule // edge_prog_receiver_test
`default_nettype wire
